// File: include/pwc_pkg.sv
// constants for the pwm counter control block
package pwc_pkg;
  localparam int          CNT_W       = 10;
  localparam int          NCH         = 4;
  // register indexes, byte address is four times the index
  localparam logic [7:0]  IDX_CH1_LOW = 8'hdb;
  localparam logic [7:0]  IDX_CTL_ONE = 8'hdc;
  localparam logic [7:0]  IDX_CH2_LOW = 8'hdd;
  localparam logic [7:0]  IDX_PERIOD  = 8'he0;
  localparam logic [7:0]  IDX_CH12_HI = 8'he1;
  localparam logic [7:0]  IDX_CH0     = 8'he2;
  localparam logic [7:0]  IDX_CH3     = 8'he3;
  localparam logic [7:0]  IDX_PRESC   = 8'he4;
  localparam logic [7:0]  IDX_INT_ST  = 8'he5;
  localparam logic [7:0]  IDX_INT_CLR = 8'he6;
  localparam logic [7:0]  IDX_INT_EN  = 8'he7;
  // control one fields
  localparam int          BIT_RUN     = 7;
  localparam int          BIT_LOAD    = 6;
  localparam int          BIT_FLAG    = 5;
  localparam int          BIT_CLR     = 4;
  // high-bit register fields
  localparam int          POS_CH1_HI  = 0;
  localparam int          POS_CH2_HI  = 2;
  // prescale select codes and tick masks
  localparam logic [1:0]  PRE_DIV16   = 2'h3;
  localparam logic [3:0]  MASK_DIV1   = 4'h0;
  localparam logic [3:0]  MASK_DIV2   = 4'h1;
  localparam logic [3:0]  MASK_DIV4   = 4'h3;
  localparam logic [3:0]  MASK_DIV16  = 4'hf;
  // reset values
  localparam logic [7:0]  RST_CTL     = 8'h00;
  localparam logic [9:0]  RST_PERIOD  = 10'h000;
  localparam logic [9:0]  RST_DUTY    = 10'h000;
  localparam logic [1:0]  RST_PRESC   = 2'h0;
endpackage : pwc_pkg

// File: logic/pwc_prescale.sv
// prescaler producing the counter tick enable
`timescale 1ns/100ps
`default_nettype none
module pwc_prescale
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  // tick
  output logic            tick_o
);
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [3:0] mask;

  always_comb
  begin
    case (sel_i)
      2'h0:    mask = MASK_DIV1;
      2'h1:    mask = MASK_DIV2;
      2'h2:    mask = MASK_DIV4;
      default: mask = MASK_DIV16;
    endcase
    div_next = run_i ? div_reg + 4'h1 : 4'h0; // R10
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 4'h0;
    else
      div_reg <= div_next;
  end

  assign tick_o = run_i && ((div_reg & mask) == mask); // R10

  a_div16_gap: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (tick_o && sel_i == PRE_DIV16) |=> (!tick_o)[*8])
    else $error("tick too soon at divide by sixteen");
endmodule : pwc_prescale
`default_nettype wire

// File: logic/pwc_channel.sv
// one channel: compare register, comparator and inversion
`timescale 1ns/100ps
`default_nettype none
module pwc_channel
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // counter side
  input  wire logic [pwc_pkg::CNT_W-1:0] cnt_i,
  input  wire logic             load_i,
  input  wire logic [pwc_pkg::CNT_W-1:0] duty_i,
  input  wire logic             inv_i,
  // output
  output logic                  out_o
);
  logic [CNT_W-1:0] cmp_reg;
  logic [CNT_W-1:0] cmp_next;
  logic             out_reg;
  logic             out_next;

  always_comb
  begin
    cmp_next = load_i ? duty_i : cmp_reg; // R2 R3
    out_next = (cnt_i < cmp_reg) ^ inv_i; // R11 R8
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_reg <= RST_DUTY;
      out_reg <= 1'b0;
    end
    else
    begin
      cmp_reg <= cmp_next;
      out_reg <= out_next;
    end
  end

  assign out_o = out_reg;

  a_chan_invert: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    1'b1 |=> out_reg == ($past(cnt_i < cmp_reg) ^ $past(inv_i)))
    else $error("channel output not compare xor invert");
  a_cmp_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    !load_i |=> $stable(cmp_reg))
    else $error("compare changed without load");
endmodule : pwc_channel
`default_nettype wire

// File: logic/pwc_top.sv
// pwm counter control with ahb-lite register slave
// Function
// R1: ten-bit down counter detects underflow
// R2: load request reloads period and duties
// R3: no load request, no reload
// R4: load request clears itself two clocks after the reload underflow
// R5: underflow sets flag, may raise interrupt
// R6: software alone clears underflow flag
// R7: counter clear zeroes counter, self-clears
// R8: invert bits flip channel outputs
// R9: counter advances only while running
// R10: prescale divides clock 1,2,4,16
// R11: channel output compares counter with compare
// R12: no load: restart from active period
`timescale 1ns/100ps
`default_nettype none
module pwc_top
  import pwc_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // pwm outputs and interrupt
  output logic [pwc_pkg::NCH-1:0]   pwm_out,
  output logic                      irq
);
  logic                  run_reg, run_next;
  logic                  load_reg, load_next;
  logic                  flag_reg, flag_next;
  logic                  clr_reg, clr_next;
  logic [3:0]            inv_reg, inv_next;
  logic [CNT_W-1:0]      period_reg, period_next;
  logic [NCH-1:0][CNT_W-1:0] duty_reg, duty_next;
  logic [1:0]            presc_reg, presc_next;
  logic                  stat_reg, stat_next;
  logic                  en_reg, en_next;
  logic [CNT_W-1:0]      cnt_reg, cnt_next;
  logic [CNT_W-1:0]      per_act_reg, per_act_next;
  logic                  done_reg, done_next;
  logic                  wr_reg, wr_next;
  logic                  rd_reg, rd_next;
  logic [7:0]            idx_reg, idx_next;
  logic                  tick;
  logic                  underflow;
  logic                  load_now;
  logic                  ctl_wr;
  logic                  addr_ok;

  // bus address phase capture
  always_comb
  begin
    addr_ok  = hsel && htrans[1] && hready && (haddr[31:10] == 22'h0);
    wr_next  = addr_ok && hwrite;
    rd_next  = addr_ok && !hwrite;
    idx_next = addr_ok ? haddr[9:2] : idx_reg;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      idx_reg <= 8'h00;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      idx_reg <= idx_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ctl_wr    = wr_reg && (idx_reg == IDX_CTL_ONE);

  // counter tick
  pwc_prescale u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run_i   (run_reg), // R9
    .sel_i   (presc_reg),
    .tick_o  (tick)
  );

  assign underflow = tick && !clr_reg && (cnt_reg == 10'h000); // R1
  assign load_now  = underflow && load_reg; // R2

  // counter and active period
  always_comb
  begin
    cnt_next     = cnt_reg;
    per_act_next = per_act_reg;
    done_next    = load_now;
    if (clr_reg)
      cnt_next = 10'h000; // R7
    else if (tick)
    begin
      if (cnt_reg != 10'h000)
        cnt_next = cnt_reg - 10'h001; // R1
      else if (load_reg)
      begin
        cnt_next     = period_reg; // R2
        per_act_next = period_reg;
      end
      else
        cnt_next = per_act_reg; // R12 R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg     <= 10'h000;
      per_act_reg <= RST_PERIOD;
      done_reg    <= 1'b0;
    end
    else
    begin
      cnt_reg     <= cnt_next;
      per_act_reg <= per_act_next;
      done_reg    <= done_next;
    end
  end

  // register writes
  always_comb
  begin
    run_next    = run_reg;
    load_next   = load_reg;
    flag_next   = flag_reg | underflow; // R5
    clr_next    = 1'b0; // R7
    inv_next    = inv_reg;
    period_next = period_reg;
    duty_next   = duty_reg;
    presc_next  = presc_reg;
    stat_next   = stat_reg | underflow; // R5
    en_next     = en_reg;
    if (done_reg)
      load_next = 1'b0; // R4
    if (ctl_wr)
    begin
      run_next  = hwdata[BIT_RUN];
      load_next = hwdata[BIT_LOAD];
      flag_next = (flag_reg & hwdata[BIT_FLAG]) | underflow; // R6
      clr_next  = hwdata[BIT_CLR];
      inv_next  = hwdata[3:0];
    end
    else if (wr_reg && idx_reg == IDX_CH1_LOW)
      duty_next[1][7:0] = hwdata[7:0];
    else if (wr_reg && idx_reg == IDX_CH2_LOW)
      duty_next[2][7:0] = hwdata[7:0];
    else if (wr_reg && idx_reg == IDX_PERIOD)
      period_next = hwdata[CNT_W-1:0];
    else if (wr_reg && idx_reg == IDX_CH12_HI)
    begin
      duty_next[1][9:8] = hwdata[POS_CH1_HI+:2];
      duty_next[2][9:8] = hwdata[POS_CH2_HI+:2];
    end
    else if (wr_reg && idx_reg == IDX_CH0)
      duty_next[0] = hwdata[CNT_W-1:0];
    else if (wr_reg && idx_reg == IDX_CH3)
      duty_next[3] = hwdata[CNT_W-1:0];
    else if (wr_reg && idx_reg == IDX_PRESC)
      presc_next = hwdata[1:0];
    else if (wr_reg && idx_reg == IDX_INT_CLR)
      stat_next = (stat_reg & ~hwdata[0]) | underflow;
    else if (wr_reg && idx_reg == IDX_INT_EN)
      en_next = hwdata[0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_reg    <= RST_CTL[BIT_RUN];
      load_reg   <= RST_CTL[BIT_LOAD];
      flag_reg   <= RST_CTL[BIT_FLAG];
      clr_reg    <= RST_CTL[BIT_CLR];
      inv_reg    <= RST_CTL[3:0];
      period_reg <= RST_PERIOD;
      duty_reg   <= {NCH{RST_DUTY}};
      presc_reg  <= RST_PRESC;
      stat_reg   <= 1'b0;
      en_reg     <= 1'b0;
    end
    else
    begin
      run_reg    <= run_next;
      load_reg   <= load_next;
      flag_reg   <= flag_next;
      clr_reg    <= clr_next;
      inv_reg    <= inv_next;
      period_reg <= period_next;
      duty_reg   <= duty_next;
      presc_reg  <= presc_next;
      stat_reg   <= stat_next;
      en_reg     <= en_next;
    end
  end

  assign irq = stat_reg && en_reg; // R5

  // read mux
  always_comb
  begin
    hrdata = 32'h0;
    if (!rd_reg)
      hrdata = 32'h0;
    else if (idx_reg == IDX_CTL_ONE)
      hrdata[7:0] = {run_reg, load_reg, flag_reg, clr_reg, inv_reg};
    else if (idx_reg == IDX_CH1_LOW)
      hrdata[7:0] = duty_reg[1][7:0];
    else if (idx_reg == IDX_CH2_LOW)
      hrdata[7:0] = duty_reg[2][7:0];
    else if (idx_reg == IDX_PERIOD)
      hrdata[CNT_W-1:0] = period_reg;
    else if (idx_reg == IDX_CH12_HI)
      hrdata[3:0] = {duty_reg[2][9:8], duty_reg[1][9:8]};
    else if (idx_reg == IDX_CH0)
      hrdata[CNT_W-1:0] = duty_reg[0];
    else if (idx_reg == IDX_CH3)
      hrdata[CNT_W-1:0] = duty_reg[3];
    else if (idx_reg == IDX_PRESC)
      hrdata[1:0] = presc_reg;
    else if (idx_reg == IDX_INT_ST)
      hrdata[0] = stat_reg;
    else if (idx_reg == IDX_INT_EN)
      hrdata[0] = en_reg;
  end

  // channels
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    pwc_channel u_ch (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cnt_i   (cnt_reg), // R11
      .load_i  (load_now), // R2
      .duty_i  (duty_reg[g]),
      .inv_i   (inv_reg[g]), // R8
      .out_o   (pwm_out[g])
    );
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_count_down: assert property ( // R1
    (tick && !clr_reg && cnt_reg != 10'h000) |=> cnt_reg == $past(cnt_reg) - 10'h001)
    else $error("counter did not step down");
  a_load_period: assert property ( // R2
    load_now |=> (cnt_reg == $past(period_reg)) && (per_act_reg == $past(period_reg)))
    else $error("period not loaded on underflow");
  a_no_load: assert property ( // R3
    !load_now |=> $stable(per_act_reg))
    else $error("active period changed without load");
  a_load_clear: assert property ( // R4
    load_now ##1 !ctl_wr |=> !load_reg)
    else $error("load request not cleared");
  a_flag_set: assert property ( // R5
    underflow |=> flag_reg && stat_reg)
    else $error("underflow flag not set");
  a_irq_raise: assert property ( // R5
    (underflow && en_reg && !(wr_reg && idx_reg == IDX_INT_EN)) |=> irq)
    else $error("interrupt not raised");
  a_flag_kept: assert property ( // R6
    (flag_reg && !ctl_wr) |=> flag_reg)
    else $error("flag cleared by hardware");
  a_clear_zero: assert property ( // R7
    clr_reg |=> cnt_reg == 10'h000 && !$past(underflow))
    else $error("counter clear failed");
  a_stop_hold: assert property ( // R9
    (!run_reg && !clr_reg) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  a_reload_act: assert property ( // R12
    (underflow && !load_reg) |=> cnt_reg == $past(per_act_reg))
    else $error("counter not reloaded from active period");

  c_load: cover property (load_now ##1 done_reg ##1 !load_reg);
  c_clear: cover property (ctl_wr && hwdata[BIT_CLR] ##1 clr_reg);
  c_irq: cover property (underflow ##1 irq);
endmodule : pwc_top
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the pwm counter control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pwc_pkg::*;
  logic           hclk;
  logic           hresetn;
  logic           hsel;
  logic           hwrite;
  logic [31:0]    haddr;
  logic [31:0]    hwdata;
  logic [31:0]    hrdata;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic           hreadyout;
  logic           hresp;
  logic           irq;
  logic [NCH-1:0] pwm_out;
  logic [NCH-1:0] held;
  logic [31:0]    v;
  int             errors;
  int             n_tests;
  int             n;
  int             ex[4] = '{4, 16, 16, 0};
  int             dv[4] = '{1, 2, 4, 16};
  localparam logic [31:0] RUN  = 32'h80;
  localparam logic [31:0] LOAD = 32'h40;
  localparam logic [31:0] FLG  = 32'h20;
  localparam logic [31:0] CLR  = 32'h10;

  pwc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out), .irq(irq));

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one single ahb-lite word transfer
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    q = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d, v);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0, v);
    chk(v, exp);
  endtask : rd

  // high cycles of one channel over sixteen clocks
  task automatic ones(input int ch, output int c);
    c = 0;
    repeat (2) @(posedge hclk);
    repeat (16)
    begin
      @(posedge hclk);
      c += (pwm_out[ch] === 1'b1) ? 1 : ((pwm_out[ch] === 1'b0) ? 0 : 100);
    end
  endtask : ones

  // clocks until the next rising edge of channel 0
  task automatic rise(output int k);
    logic a;
    k = 0;
    a = pwm_out[0];
    @(posedge hclk);
    while (!(a === 1'b0 && pwm_out[0] === 1'b1) && k < 200)
    begin
      a = pwm_out[0];
      k++;
      @(posedge hclk);
    end
    k++;
  endtask : rise

  task automatic meas(output int p);
    rise(p);
    rise(p);
    rise(p);
  endtask : meas

  task automatic end_sim;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #(40 * 20000);
    errors++;
    end_sim();
  end

  initial
  begin
    errors = 0;
    n_tests = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(pwm_out), 32'h0);
    rd(IDX_CTL_ONE, 32'h0);
    rd(IDX_CH1_LOW, 32'h0);
    rd(IDX_CH2_LOW, 32'h0);
    wr(IDX_CH1_LOW, 32'ha5);
    rd(IDX_CH1_LOW, 32'ha5);
    wr(IDX_CH2_LOW, 32'h5a);
    rd(IDX_CH2_LOW, 32'h5a);
    rd(8'h10, 32'h0);
    // first run with load request
    wr(IDX_PERIOD, 32'h3);
    wr(IDX_CH0, 32'h1);
    wr(IDX_INT_EN, 32'h1);
    wr(IDX_CTL_ONE, RUN | LOAD);
    repeat (4) @(posedge hclk);
    rd(IDX_CTL_ONE, RUN | FLG);
    chk(32'(irq), 32'h1);
    meas(n);
    chk(n, 4);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_CTL_ONE, RUN | FLG);
      ones(i, n);
      chk(n, ex[i]);
      wr(IDX_CTL_ONE, RUN | FLG | (32'h1 << i));
      ones(i, n);
      chk(n, 16 - ex[i]);
    end
    // duty change without and with load request
    wr(IDX_CTL_ONE, RUN | FLG);
    wr(IDX_CH0, 32'h3);
    ones(0, n);
    chk(n, 4);
    wr(IDX_CTL_ONE, RUN | LOAD | FLG);
    repeat (8) @(posedge hclk);
    rd(IDX_CTL_ONE, RUN | FLG);
    ones(0, n);
    chk(n, 12);
    for (int s = 1; s < 4; s++)
    begin
      wr(IDX_PRESC, s);
      meas(n);
      chk(n, 4 * dv[s]);
    end
    // mask, stop, clear
    wr(IDX_INT_EN, 32'h0);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    wr(IDX_CTL_ONE, 32'h0);
    wr(IDX_CTL_ONE, 32'h0);
    wr(IDX_INT_CLR, 32'h1);
    wr(IDX_INT_EN, 32'h1);
    rd(IDX_INT_ST, 32'h0);
    rd(IDX_CTL_ONE, 32'h0);
    held = pwm_out;
    repeat (64) @(posedge hclk);
    chk(32'(pwm_out), 32'(held));
    rd(IDX_INT_ST, 32'h0);
    chk(32'(irq), 32'h0);
    // counter clear against a long period
    wr(IDX_PRESC, 32'h0);
    wr(IDX_PERIOD, 32'h3ff);
    wr(IDX_CTL_ONE, RUN | LOAD);
    repeat (20) @(posedge hclk);
    wr(IDX_CTL_ONE, 32'h0);
    wr(IDX_CTL_ONE, 32'h0);
    wr(IDX_INT_CLR, 32'h1);
    wr(IDX_CTL_ONE, CLR);
    rd(IDX_CTL_ONE, 32'h0);
    wr(IDX_CTL_ONE, RUN);
    repeat (4) @(posedge hclk);
    rd(IDX_INT_ST, 32'h1);
    rd(IDX_CTL_ONE, RUN | FLG);
    chk(32'(irq), 32'h1);
    // reset in mid-run returns every register to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(pwm_out), 32'h0);
    chk(32'(irq), 32'h0);
    hresetn <= 1'b1;
    rd(IDX_CTL_ONE, 32'h0);
    rd(IDX_PERIOD, 32'h0);
    rd(IDX_INT_ST, 32'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
